// *** design/rcp_parser.sv ***
/*
  relay channel command parser: takes ascii open/close commands byte by
  byte, checks the channel descriptor, keeps a relay image per module and
  issues control register writes, then answers with one reply byte.
  assumes a byte source with valid/ready, LF-terminated commands, and a
  mode level from the host side selecting register-based control.
*/
// Function
// - decode commands, compute register data itself
// - register mode: no watching, no state record
// - register mode writes pass well under 9us
// - descriptor is (@ address (list) )
// - module address only 1 through 12
// - channels one or two digits, 0..16
// - comma separates channel entries
// - colon span expands to every channel inclusive
// - open clears, close sets selected channels
// - command features refused in register mode
// - ascii commands in, reply byte out
// - hold off 10 ms settling after writes
`default_nettype none
module rcp_parser
  import rcp_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = rcp_pkg::SETTLE_CYC
) (
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic [7:0]       RX_DATA,
  input  wire logic             RX_VALID,
  output logic                  RX_READY,
  output logic      [7:0]       RPLY_DATA,
  output logic                  RPLY_VALID,
  input  wire logic             MODE_REGB,
  input  wire logic             HOST_WR,
  input  wire logic [3:0]       HOST_MOD,
  input  wire logic [1:0]       HOST_REG,
  input  wire logic [REG_W-1:0] HOST_DATA,
  output logic                  RLY_WR,
  output logic      [3:0]       RLY_MOD,
  output logic      [1:0]       RLY_REG,
  output logic      [REG_W-1:0] RLY_DATA
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  // settle count must be at least one cycle
  if (SETTLE_CYCLES < 1) begin : g_chk
    $error("rcp_parser: SETTLE_CYCLES must be at least 1");
  end

  // true for an ascii decimal digit
  function automatic logic is_digit(input logic [7:0] b);
    return (b >= CH_ZERO) && (b <= CH_NINE);
  endfunction

  // value of a two-digit field after one more digit
  function automatic logic [6:0] dec_acc(input logic [6:0] n,
                                         input logic [7:0] b);
    logic [7:0] d;
    d = b - CH_ZERO;
    return 7'(n * DEC_TEN + d[6:0]);
  endfunction

  rcp_state_t      st_q, st_d;      // parser state
  logic [6:0]      num_q, num_d;    // number being read
  logic [1:0]      nd_q, nd_d;      // digits seen in that number
  logic [6:0]      lo_q, lo_d;      // first channel of a pending span
  logic            rng_q, rng_d;    // a colon was seen
  logic [NCH-1:0]  mask_q, mask_d;  // selected channels
  logic [3:0]      mod_q, mod_d;    // module address
  logic            open_q, open_d;  // open (1) or close (0) command
  logic [7:0]      code_q, code_d;  // reply byte to send
  logic [CW-1:0]   cnt_q, cnt_d;    // settle counter
  logic            ready_q;         // byte accepted when valid
  logic            rv_q, rv_d;      // reply strobe
  logic [7:0]      rd_q, rd_d;      // reply data
  logic [NCH-1:0]  shadow [1:12];   // relay image per module address

  logic            taken;           // byte accepted this cycle
  logic            dig;             // byte is a digit
  logic            is_lf;           // byte ends a command
  logic [6:0]      num_nx;          // number with this digit added
  logic [6:0]      span_lo;         // low end of current entry
  logic [NCH-1:0]  ent_mask;        // channels of current entry
  logic            ent_ok;          // current entry is well formed
  logic            mod_ok;          // module address in range
  logic [NCH-1:0]  cur;             // image of the addressed module
  logic [NCH-1:0]  nb;              // image after the command
  logic            start;           // launch register writes
  logic            bad;             // syntax fault on this byte
  logic            seq_busy;        // write sequencer running

  assign taken   = RX_VALID && ready_q;
  assign dig     = is_digit(RX_DATA);
  assign is_lf   = (RX_DATA == CH_LF);
  assign num_nx  = dec_acc(num_q, RX_DATA);
  assign span_lo = rng_q ? lo_q : num_q;
  assign ent_ok  = (nd_q != 2'h0) && (num_q <= CH_MAX)
                   && (!rng_q || lo_q <= num_q);
  assign mod_ok  = (nd_q != 2'h0) && (num_q >= MOD_MIN)
                   && (num_q <= MOD_MAX);
  assign cur     = shadow[mod_q];
  assign nb      = open_q ? (cur & ~mask_q) : (cur | mask_q);
  assign start   = (st_q == S_WR);

  rcp_chan_mask #(.NCH(NCH)) u_mask (
    .lo   (span_lo),
    .hi   (num_q),
    .mask (ent_mask)
  );

  // parser next state; all but the reply strobe hold unless a byte or the write, settle or reply states move them
  always_comb begin
    st_d   = st_q;
    num_d  = num_q;
    nd_d   = nd_q;
    lo_d   = lo_q;
    rng_d  = rng_q;
    mask_d = mask_q;
    mod_d  = mod_q;
    open_d = open_q;
    code_d = code_q;
    cnt_d  = cnt_q;
    rv_d   = 1'b0;
    rd_d   = rd_q;
    bad    = 1'b0;
    case (st_q)
      S_KW: begin
        // keyword: only the first letter matters
        if (taken && !is_lf) begin
          if (MODE_REGB) begin
            code_d = RPL_REGB;
            st_d   = S_ERR;
          end else if (RX_DATA == CH_O) begin
            open_d = 1'b1;
            st_d   = S_PRE;
          end else if (RX_DATA == CH_C) begin
            open_d = 1'b0;
            st_d   = S_PRE;
          end else begin
            bad = 1'b1;
          end
        end
      end
      S_PRE: begin
        // skip rest of keyword up to the opening parenthesis
        if (taken && RX_DATA == CH_LPAR) begin
          st_d = S_AT;
        end else if (taken && is_lf) begin
          bad = 1'b1;
        end
      end
      S_AT: begin
        if (taken) begin
          if (RX_DATA == CH_AT) begin
            st_d = S_MOD;
          end else begin
            bad = 1'b1;
          end
        end
      end
      S_MOD: begin
        if (taken) begin
          if (dig && nd_q < MAX_DIG) begin
            num_d = num_nx;
            nd_d  = nd_q + 2'h1;
          end else if (RX_DATA == CH_LPAR && mod_ok) begin
            mod_d = num_q[3:0];
            num_d = '0;
            nd_d  = '0;
            st_d  = S_CH;
          end else begin
            bad = 1'b1;
          end
        end
      end
      S_CH: begin
        if (taken) begin
          if (dig && nd_q < MAX_DIG) begin
            num_d = num_nx;
            nd_d  = nd_q + 2'h1;
          end else if (RX_DATA == CH_COLON && nd_q != 2'h0 && !rng_q
                       && num_q <= CH_MAX) begin
            lo_d  = num_q;
            rng_d = 1'b1;
            num_d = '0;
            nd_d  = '0;
          end else if (RX_DATA == CH_COMMA && ent_ok) begin
            mask_d = mask_q | ent_mask;
            num_d  = '0;
            nd_d   = '0;
            rng_d  = 1'b0;
          end else if (RX_DATA == CH_RPAR && ent_ok) begin
            mask_d = mask_q | ent_mask;
            st_d   = S_CLS;
          end else begin
            bad = 1'b1;
          end
        end
      end
      S_CLS: begin
        if (taken) begin
          if (RX_DATA == CH_RPAR) begin
            st_d = S_END;
          end else begin
            bad = 1'b1;
          end
        end
      end
      S_END: begin
        if (taken) begin
          if (is_lf) begin
            st_d = S_WR;
          end else begin
            bad = 1'b1;
          end
        end
      end
      S_ERR: begin
        // drop bytes to the end of the faulty line
        if (taken && is_lf) begin
          st_d = S_RPLY;
        end
      end
      S_WR: begin
        // image computed here, writes launched
        // this cycle already counts as the first settle cycle
        cnt_d  = CW'(1);
        code_d = RPL_OK;
        // settle in the drain state, or reply at once for one cycle
        st_d   = (SETTLE_CYCLES > 1) ? S_ERR : S_RPLY;
      end
      S_RPLY: begin
        // one reply byte, then back to idle
        rv_d   = 1'b1;
        rd_d   = code_q;
        num_d  = '0;
        nd_d   = '0;
        rng_d  = 1'b0;
        mask_d = '0;
        code_d = RPL_OK;
        st_d   = S_KW;
      end
      default: begin
        st_d = S_KW;
      end
    endcase
    // a fault goes to drain mode, or straight to reply on a line end
    if (bad) begin
      code_d = RPL_SYN;
      st_d   = is_lf ? S_RPLY : S_ERR;
    end
    // settle wait reuses the drain state with code OK
    if (st_q == S_ERR && code_q == RPL_OK) begin
      cnt_d = cnt_q + CW'(1);
      st_d  = (cnt_q >= CW'(SETTLE_CYCLES - 1)) ? S_RPLY : S_ERR;
    end
  end

  // state registers; ready follows the next state so it is a flop
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q    <= S_KW;
      num_q   <= '0;
      nd_q    <= '0;
      lo_q    <= '0;
      rng_q   <= 1'b0;
      mask_q  <= '0;
      mod_q   <= MOD_MIN[3:0];
      open_q  <= 1'b0;
      code_q  <= RPL_OK;
      cnt_q   <= '0;
      ready_q <= 1'b1;
      rv_q    <= 1'b0;
      rd_q    <= RPL_OK;
    end else begin
      st_q    <= st_d;
      num_q   <= num_d;
      nd_q    <= nd_d;
      lo_q    <= lo_d;
      rng_q   <= rng_d;
      mask_q  <= mask_d;
      mod_q   <= mod_d;
      open_q  <= open_d;
      code_q  <= code_d;
      cnt_q   <= cnt_d;
      // no new byte while writing or settling
      ready_q <= (st_d != S_WR) && (st_d != S_RPLY)
                 && !(st_d == S_ERR && code_d == RPL_OK);
      rv_q    <= rv_d;
      rd_q    <= rd_d;
    end
  end

  // relay image; only a good command writes it
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int m = 1; m <= 12; m++) begin
        shadow[m] <= '0;
      end
    end else if (start) begin
      // reached only from a clean descriptor
      shadow[mod_q] <= nb;
    end
  end

  // host writes go straight out, never recorded in the image
  rcp_wr_seq #(.NCH(NCH)) u_seq (
    .clk      (CLK),
    .rst      (SYS_RST),
    .start    (start),
    .mod      (mod_q),
    .bits     (nb),
    .byp_wr   (HOST_WR && MODE_REGB),
    .byp_mod  (HOST_MOD),
    .byp_reg  (HOST_REG),
    .byp_data (HOST_DATA),
    .wr_q     (RLY_WR),
    .mod_q    (RLY_MOD),
    .reg_q    (RLY_REG),
    .data_q   (RLY_DATA),
    .busy_q   (seq_busy)
  );

  assign RX_READY   = ready_q;
  assign RPLY_VALID = rv_q;
  assign RPLY_DATA  = rd_q;

  property p_settle_hold;
    @(posedge CLK) disable iff (SYS_RST)
      start |=> (!RX_READY) [*8];
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("ready early");

  property p_mod_range;
    @(posedge CLK) disable iff (SYS_RST)
      start |-> (mod_q >= MOD_MIN[3:0] && mod_q <= MOD_MAX[3:0]);
  endproperty
  a_mod_range: assert property (p_mod_range) else $error("address range");

  property p_image;
    @(posedge CLK) disable iff (SYS_RST)
      start |=> (cur == $past(nb));
  endproperty
  a_image: assert property (p_image) else $error("image not updated");

  property p_err_nowrite;
    @(posedge CLK) disable iff (SYS_RST)
      (st_q == S_ERR && code_q != RPL_OK) |=> (st_q == S_ERR || st_q == S_RPLY);
  endproperty
  a_err_nowrite: assert property (p_err_nowrite) else $error("write after fault");

  property p_regb_refuse;
    @(posedge CLK) disable iff (SYS_RST)
      (st_q == S_KW && taken && MODE_REGB && !is_lf)
        |=> (st_q == S_ERR && code_q == RPL_REGB);
  endproperty
  a_regb_refuse: assert property (p_regb_refuse) else $error("regb accepted");

  property p_reply;
    @(posedge CLK) disable iff (SYS_RST)
      (st_q == S_RPLY) |=> (RPLY_VALID && RPLY_DATA == $past(code_q));
  endproperty
  a_reply: assert property (p_reply) else $error("reply missing");

  property p_mask_nonzero;
    @(posedge CLK) disable iff (SYS_RST)
      (st_q == S_CLS) |-> (mask_q != '0 && (mask_q >> (CH_MAX + 7'h1)) == '0);
  endproperty
  a_mask_nonzero: assert property (p_mask_nonzero) else $error("empty list");

  property p_write_out;
    @(posedge CLK) disable iff (SYS_RST)
      start |-> ##2 (RLY_WR && RLY_MOD == $past(mod_q, 2));
  endproperty
  a_write_out: assert property (p_write_out) else $error("no write");
endmodule
`default_nettype wire

// *** design/rcp_pkg.sv ***
/*
  shared constants for the relay channel command parser: ascii codes,
  descriptor limits, reply codes, timing figures and parser states.
  assumes a single 200 MHz clock domain.
*/
`default_nettype none
package rcp_pkg;
  // clock period in ns
  localparam int CLK_PERIOD_NS = 5;
  // relay contact settling, in ms, and derived cycle count (longest: floor)
  localparam int SETTLE_MS  = 10;
  localparam int SETTLE_CYC = SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  // register-based operation bound, in us, and derived cycle count
  localparam int REGB_MAX_US  = 9;
  localparam int REGB_MAX_CYC = REGB_MAX_US * 1000 / CLK_PERIOD_NS;

  // ascii characters the parser knows
  localparam logic [7:0] CH_LPAR  = 8'h28;
  localparam logic [7:0] CH_RPAR  = 8'h29;
  localparam logic [7:0] CH_AT    = 8'h40;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_O     = 8'h4F;
  localparam logic [7:0] CH_C     = 8'h43;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;

  // reply bytes
  localparam logic [7:0] RPL_OK   = 8'h30;
  localparam logic [7:0] RPL_SYN  = 8'h31;
  localparam logic [7:0] RPL_REGB = 8'h32;

  // descriptor limits
  localparam logic [6:0] MOD_MIN = 7'h01;
  localparam logic [6:0] MOD_MAX = 7'h0C;
  localparam logic [6:0] CH_MAX  = 7'h10;
  localparam logic [6:0] DEC_TEN = 7'h0A;
  localparam logic [1:0] MAX_DIG = 2'h2;
  localparam int NCH   = 17;
  localparam int NREG  = 3;
  localparam int REG_W = 8;

  // parser states, one-hot
  typedef enum logic [9:0] {
    S_KW   = 10'h001,
    S_PRE  = 10'h002,
    S_AT   = 10'h004,
    S_MOD  = 10'h008,
    S_CH   = 10'h010,
    S_CLS  = 10'h020,
    S_END  = 10'h040,
    S_ERR  = 10'h080,
    S_WR   = 10'h100,
    S_RPLY = 10'h200
  } rcp_state_t;
endpackage
`default_nettype wire

// *** design/rcp_chan_mask.sv ***
/*
  combinational span decoder: sets every channel bit from lo to hi inclusive.
  assumes lo <= hi is checked by the caller; an empty span gives zero.
*/
`default_nettype none
module rcp_chan_mask #(
  parameter int NCH = 17
) (
  input  wire logic [6:0]     lo,
  input  wire logic [6:0]     hi,
  output logic      [NCH-1:0] mask
);
  import rcp_pkg::*;

  if (NCH < 1 || NCH > 127) begin : g_chk
    $error("rcp_chan_mask: NCH out of range");
  end

  // one comparator pair per channel
  for (genvar i = 0; i < NCH; i++) begin : g_bit
    assign mask[i] = (7'(i) >= lo) && (7'(i) <= hi);
  end
endmodule
`default_nettype wire

// *** design/rcp_wr_seq.sv ***
/*
  control register write sequencer: turns a channel image into three byte
  writes, or passes a direct host write straight through when idle.
  assumes start is a one-cycle pulse and never arrives while busy.
*/
`default_nettype none
module rcp_wr_seq
  import rcp_pkg::*;
#(
  parameter int NCH = rcp_pkg::NCH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [3:0]       mod,
  input  wire logic [NCH-1:0]   bits,
  input  wire logic             byp_wr,
  input  wire logic [3:0]       byp_mod,
  input  wire logic [1:0]       byp_reg,
  input  wire logic [REG_W-1:0] byp_data,
  output logic                  wr_q,
  output logic      [3:0]       mod_q,
  output logic      [1:0]       reg_q,
  output logic      [REG_W-1:0] data_q,
  output logic                  busy_q
);
  if (NCH > NREG * REG_W) begin : g_chk
    $error("rcp_wr_seq: too many channels for three registers");
  end

  logic [1:0]           idx_q;   // register being written
  logic [NREG*REG_W-1:0] img_q;  // latched, zero padded image
  logic [REG_W-1:0]     slice;   // byte for idx_q
  logic                 last;    // final register of the image

  assign slice = img_q[idx_q*REG_W +: REG_W];
  assign last  = (idx_q == 2'(NREG - 1));

  // sequence writes; direct writes only while no sequence runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q   <= 1'b0;
      mod_q  <= 4'h0;
      reg_q  <= 2'h0;
      data_q <= '0;
      busy_q <= 1'b0;
      idx_q  <= 2'h0;
      img_q  <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      idx_q  <= 2'h0;
      img_q  <= (NREG*REG_W)'(bits);
      mod_q  <= mod;
      wr_q   <= 1'b0;
    end else if (busy_q) begin
      // one register per cycle, channel 0 byte first
      wr_q   <= 1'b1;
      reg_q  <= idx_q;
      data_q <= slice;
      idx_q  <= idx_q + 2'h1;
      busy_q <= !last;
    end else begin
      wr_q   <= byp_wr;
      mod_q  <= byp_wr ? byp_mod : mod_q;
      reg_q  <= byp_wr ? byp_reg : reg_q;
      data_q <= byp_wr ? byp_data : data_q;
    end
  end

  property p_byp_fast;
    @(posedge clk) disable iff (rst)
      (byp_wr && !busy_q && !start) |=> (wr_q && data_q == $past(byp_data)
        && reg_q == $past(byp_reg));
  endproperty
  a_byp_fast: assert property (p_byp_fast) else $error("direct write late");

  property p_three_writes;
    @(posedge clk) disable iff (rst)
      start |=> ##1 (wr_q && reg_q == 2'h0) ##1 (wr_q && reg_q == 2'h1)
        ##1 (wr_q && reg_q == 2'h2);
  endproperty
  a_three_writes: assert property (p_three_writes) else $error("write order");
endmodule
`default_nettype wire

// *** tb/rcp_host_model.sv ***
/*
  host-side command source: offers ascii command lines one byte at a time
  on a valid/ready link and waits for the single reply byte.
  assumes the parser's ready is registered, so its value just after an edge
  is the value sampled at the next edge.
*/
`default_nettype none
module rcp_host_model (
  input  wire logic       clk,
  input  wire logic       rx_ready,
  input  wire logic [7:0] rpl_data,
  input  wire logic       rpl_valid,
  output logic      [7:0] rx_data,
  output logic            rx_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle link: nothing offered
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
  end

  // host line sender
  // each byte held until taken; a released data line shows its inverse so
  // a parser that reads it late cannot see the old byte by luck
  task automatic send_line(input string s, output logic [7:0] rpl, output int lat,
                           output bit ok);
    int n;
    ok  = 1'b1;
    rpl = 8'h00;
    lat = 0;
    for (int i = 0; i <= s.len(); i++) begin
      rx_data  = (i == s.len()) ? rcp_pkg::CH_LF : s[i];
      rx_valid = 1'b1;
      n = 0;
      while (rx_ready !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n == 100) ok = 1'b0;
      @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
    // reply wait, counted in edges after the one that took the line end
    while (rpl_valid !== 1'b1 && lat < 200) begin
      @(posedge clk);
      #1;
      lat++;
    end
    if (lat == 200) ok = 1'b0;
    rpl = rpl_data;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
  self-checking bench for the relay channel command parser: the host model
  sends lines, direct register writes come from here, every control
  register write is logged and compared with images kept by hand.
  assumes the short settle count below and one clock domain.
*/
`default_nettype none
module tb;
  import rcp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int S = 16;  // shortened settle wait, keeps the run brief

  logic       clk, sys_rst, mode_regb, host_wr;
  logic [3:0] host_mod, rly_mod;
  logic [1:0] host_reg, rly_reg;
  logic [7:0] host_data, rx_data, rpl_data, rly_data;
  logic       rx_valid, rx_ready, rpl_valid, rly_wr;
  logic [13:0] wq[$];     // logged writes: module, register, data
  int          num_errors;
  int          total_checks;

  rcp_parser #(.SETTLE_CYCLES(S)) i_rcp_parser (
    .CLK(clk), .SYS_RST(sys_rst), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RPLY_DATA(rpl_data), .RPLY_VALID(rpl_valid),
    .MODE_REGB(mode_regb), .HOST_WR(host_wr), .HOST_MOD(host_mod),
    .HOST_REG(host_reg), .HOST_DATA(host_data), .RLY_WR(rly_wr),
    .RLY_MOD(rly_mod), .RLY_REG(rly_reg), .RLY_DATA(rly_data)
  );

  rcp_host_model i_rcp_host_model (
    .clk(clk), .rx_ready(rx_ready), .rpl_data(rpl_data),
    .rpl_valid(rpl_valid), .rx_data(rx_data), .rx_valid(rx_valid)
  );

  // free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // log writes mid-cycle, away from the edge that changes them
  always @(negedge clk) begin
    if (rly_wr === 1'b1) wq.push_back({rly_mod, rly_reg, rly_data});
  end

  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one line: reply, latency and the three register writes (or none)
  task automatic cmd(input string s, input logic [7:0] rp, input logic [3:0] m,
                     input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
    logic [7:0] got;
    logic [7:0] d[3];
    int         lat;
    bit         ok;
    d = '{d0, d1, d2};
    wq.delete();
    i_rcp_host_model.send_line(s, got, lat, ok);
    if (!ok) begin
      num_errors++;
      $display("Error at %0t: handshake timed out", $time);
      conclude();
    end
    check(got, rp, "reply");
    // latency counts edges after the edge that took the line end
    if (rp == RPL_OK) check(16'(lat), 16'(1 + S), "ok latency");
    if (rp != RPL_OK) check(16'(lat), 16'h0001, "refusal latency");
    check(16'(wq.size()), (rp == RPL_OK) ? 16'h0003 : 16'h0000, "write count");
    if (rp == RPL_OK && wq.size() == 3) begin
      for (int r = 0; r < 3; r++) begin
        check(16'(wq[r]), 16'({m, r[1:0], d[r]}), "write");
      end
    end
  endtask

  task automatic t_reset();
    check(16'(rx_ready), 16'h0001, "ready after reset");
    check(16'(rpl_valid), 16'h0000, "reply idle");
    check(16'(rpl_data), 16'(RPL_OK), "reply data");
    check(16'(rly_wr), 16'h0000, "write idle");
    check(16'({rly_mod, rly_reg, rly_data}), 16'h0000, "write outputs idle");
  endtask

  task automatic t_close_one();
    cmd("CLOSE (@8(1))", RPL_OK, 4'h8, 8'h02, 8'h00, 8'h00);
  endtask

  // list and span mixed, all three registers touched
  task automatic t_close_list();
    cmd("CLOSE (@8(0,10:16))", RPL_OK, 4'h8, 8'h03, 8'hFC, 8'h01);
  endtask

  // range and syntax faults: each refused with no write at all
  task automatic t_bad();
    string bad[9];
    bad = '{"CLOSE (@13(2))", "CLOSE (@0(2))", "CLOSE (@8(17))",
            "CLOSE (@8(5:3))", "CLOSE (@8(2x))", "CLOSE (8(2))",
            "XLOSE (@8(2))", "CLOSE", "CLOSE (@8(001))"};
    foreach (bad[i]) cmd(bad[i], RPL_SYN, 4'h0, 8'h00, 8'h00, 8'h00);
  endtask

  // image must still hold the earlier closes, untouched by the faults
  task automatic t_open_mixed();
    cmd("OPEN (@8(1,11:12))", RPL_OK, 4'h8, 8'h01, 8'hE4, 8'h01);
    cmd("OPEN (@8(0:16))", RPL_OK, 4'h8, 8'h00, 8'h00, 8'h00);
  endtask

  // address and channel limits, two-digit channel form
  task automatic t_bounds();
    cmd("CLOSE (@12(16))", RPL_OK, 4'hC, 8'h00, 8'h00, 8'h01);
    cmd("CLOSE (@1(00,7))", RPL_OK, 4'h1, 8'h81, 8'h00, 8'h00);
  endtask

  // second reset between lines: outputs idle and the module 1 image cleared again
  task automatic t_mid_reset();
    sys_rst = 1'b1;
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    cmd("CLOSE (@1(1))", RPL_OK, 4'h1, 8'h02, 8'h00, 8'h00);
  endtask

  // mode only changed between lines, parser idle
  task automatic t_reg_mode();
    mode_regb = 1'b1;
    cmd("CLOSE (@5(2))", RPL_REGB, 4'h5, 8'h00, 8'h00, 8'h00);
    wq.delete();
    host_mod  = 4'h5;
    host_reg  = 2'h0;
    host_data = 8'hFF;
    host_wr   = 1'b1;
    @(posedge clk);
    #1;
    host_wr   = 1'b0;
    host_data = 8'h00;
    repeat (4) @(posedge clk);
    #1;
    check(16'(wq.size()), 16'h0001, "direct write count");
    if (wq.size() == 1) check(16'(wq[0]), {2'h0, 4'h5, 2'h0, 8'hFF}, "direct write");
    mode_regb = 1'b0;
    // host strobes outside register mode never reach the relays
    wq.delete();
    host_wr = 1'b1;
    @(posedge clk);
    #1;
    host_wr = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(16'(wq.size()), 16'h0000, "stray direct write");
    // direct write must not have entered the image
    cmd("CLOSE (@5(2))", RPL_OK, 4'h5, 8'h04, 8'h00, 8'h00);
  endtask

  // main sequence
  initial begin
    num_errors   = 0;
    total_checks = 0;
    sys_rst   = 1'b1;
    mode_regb = 1'b0;
    host_wr   = 1'b0;
    host_mod  = 4'h0;
    host_reg  = 2'h0;
    host_data = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_close_one();
    t_close_list();
    t_bad();
    t_open_mixed();
    t_bounds();
    t_mid_reset();
    t_reg_mode();
    conclude();
  end
endmodule
`default_nettype wire
